// ### design/scg_pkg.sv
// Package of constants for the system clock generation block
package scg_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SCG_TUNING_IDX = 8'h96;
    localparam logic [9:0] SCG_TUNING_ADDR = {SCG_TUNING_IDX, 2'b00};
    localparam logic [9:0] SCG_DIVIDER_ADDR = 10'h000;
    localparam logic [9:0] SCG_STATUS_ADDR = 10'h004;
    localparam logic [9:0] SCG_PORT_ADDR = 10'h008;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int SCG_CLOCK_OUTPUT_PIN_EN_BIT = 6;
    localparam int SCG_TUNE_W = 6;
    localparam logic [7:0] SCG_DIVIDER_RESET = 8'h00;
    localparam logic [5:0] SCG_TUNE_FACTORY_DEFAULT = 6'h20;
    // ------------------------------------------------------------
    // Wake-up hold counts in oscillator cycles, then settle time in clock cycles
    // ------------------------------------------------------------
    localparam int SCG_WAKE_CRYSTAL_CYCLES = 992;
    localparam int SCG_WAKE_OTHER_CYCLES = 224;
    localparam real SCG_SETTLE_US = 100.0;
    localparam real SCG_CLOCK_MHZ = 125.0;
    localparam int SCG_SETTLE_CYCLES = int'(SCG_SETTLE_US * SCG_CLOCK_MHZ);
    // ------------------------------------------------------------
    // Oscillator source selection
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        SCG_SRC_XTAL_LOW = 3'h0,
        SCG_SRC_XTAL_MED = 3'h1,
        SCG_SRC_XTAL_HIGH = 3'h2,
        SCG_SRC_RC = 3'h3,
        SCG_SRC_WATCHDOG = 3'h4,
        SCG_SRC_EXTERNAL = 3'h7
    } scg_source_type;
endpackage

// ### design/scg_sync.sv
// Two-flop synchroniser for pin-side inputs
`timescale 1ns/1ps
module scg_sync
    import scg_pkg::*;
#(
    parameter int WIDTH = 1
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] stage1;
    // First stage feeds only the second; resets high so a high pin gives no false rise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            stage1 <= '1;
            q_o <= '1;
        end
        else
        begin
            stage1 <= d_i;
            q_o <= stage1;
        end
    end
endmodule // scg_sync

// ### design/scg_top.sv
// System clock generation: source select, divider, clock output, tuning register
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module scg_top
    import scg_pkg::*;
#(
    parameter int SETTLE_CYCLES = SCG_SETTLE_CYCLES,
    parameter int DIV_MAX = 256
)
(
    // Clock and reset
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic POR_I,
    // Nonvolatile configuration
    input wire logic [2:0] OSC_SOURCE_CFG_I,
    input wire logic RTC_USES_CRYSTAL_I,
    input wire logic [5:0] TUNE_FACTORY_I,
    // Raw oscillator sources
    input wire logic CRYSTAL_INPUT_PIN_I,
    input wire logic INTERNAL_RC_CLOCK_I,
    input wire logic WATCHDOG_OSC_I,
    // Wake request
    input wire logic WAKE_I,
    // Second crystal pin port function
    input wire logic PORT_OUT_I,
    input wire logic PORT_OE_I,
    output logic CRYSTAL_OUTPUT_PIN_O,
    output logic CRYSTAL_OUTPUT_PIN_OE_O,
    // Derived clock enables and trim
    output logic CPU_CLOCK_EN_O,
    output logic MACHINE_CYCLE_O,
    output logic PERIPH_CLOCK_EN_O,
    output logic CPU_HELD_O,
    output logic [5:0] RC_TUNE_O,
    output logic XTAL_RANGE_VALID_O,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP
);
    // Elaboration checks: the divider register is eight bits wide
    if (DIV_MAX < 1 || DIV_MAX > 256)
    begin : g_div_check
        $error("DIV_MAX out of range");
    end
    if (SETTLE_CYCLES < 1)
    begin : g_settle_check
        $error("SETTLE_CYCLES must be positive");
    end

    // ------------------------------------------------------------
    // Source decode
    // ------------------------------------------------------------
    function automatic logic is_crystal(input logic [2:0] s);
        is_crystal = (s == SCG_SRC_XTAL_LOW) || (s == SCG_SRC_XTAL_MED) ||
            (s == SCG_SRC_XTAL_HIGH);
    endfunction

    // config latch
    // Source follows OSC_SOURCE_CFG_I every cycle outside reset; system reset loads the RC source
    logic [2:0] source;
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            source <= SCG_SRC_RC;
        else
            source <= OSC_SOURCE_CFG_I;
    end

    assign XTAL_RANGE_VALID_O = is_crystal(source) || source == SCG_SRC_RC ||
        source == SCG_SRC_WATCHDOG || source == SCG_SRC_EXTERNAL;

    // ------------------------------------------------------------
    // Oscillator synchronisation and selection
    // ------------------------------------------------------------
    logic [2:0] osc_sync;
    scg_sync #(.WIDTH(3)) u_sync
    (
        .clk_i(CLOCK_I),
        .rst_i(SRST_I),
        .d_i({WATCHDOG_OSC_I, INTERNAL_RC_CLOCK_I, CRYSTAL_INPUT_PIN_I}),
        .q_o(osc_sync)
    );

    logic osc_level;
    always_comb
    begin
        case (source)
            SCG_SRC_XTAL_LOW, SCG_SRC_XTAL_MED, SCG_SRC_XTAL_HIGH,
            SCG_SRC_EXTERNAL: osc_level = osc_sync[0];
            SCG_SRC_RC: osc_level = osc_sync[1];
            SCG_SRC_WATCHDOG: osc_level = osc_sync[2];
            default: osc_level = osc_sync[1];
        endcase
    end

    // Rising edge of the chosen oscillator is one oscillator tick
    // Starts high like the synchroniser, so leaving reset never fakes a tick
    logic osc_prev;
    logic osc_tick;
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            osc_prev <= 1'b1;
        else
            osc_prev <= osc_level;
    end
    assign osc_tick = osc_level & ~osc_prev;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] divider;
    logic clock_output_pin_en;
    logic [5:0] tune;
    logic wr_pend;
    logic [9:0] wr_addr;
    logic bus_go;
    assign bus_go = HSEL && HREADY && HTRANS[1];

    // Address phase capture
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 10'h000;
        end
        else
        begin
            wr_pend <= bus_go && HWRITE;
            wr_addr <= HADDR[9:0];
        end
    end

    // divider register
    // Counter compares against it at once, so a write can cut the current divider cycle short
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            divider <= SCG_DIVIDER_RESET;
        else if (wr_pend && wr_addr == SCG_DIVIDER_ADDR)
            divider <= HWDATA[7:0];
    end

    // tuning layout
    // Only power-on reset and bus writes touch this register; system reset leaves it
    always_ff @(posedge CLOCK_I)
    begin
        if (POR_I)
        begin
            tune <= TUNE_FACTORY_I;
            clock_output_pin_en <= 1'b0;
        end
        else if (wr_pend && wr_addr == SCG_TUNING_ADDR)
        begin
            tune <= HWDATA[SCG_TUNE_W-1:0];
            clock_output_pin_en <= HWDATA[SCG_CLOCK_OUTPUT_PIN_EN_BIT];
        end
    end
    assign RC_TUNE_O = tune;

    // ------------------------------------------------------------
    // Wake-up hold
    // ------------------------------------------------------------
    typedef enum logic [1:0] {SCG_WAKE_OSC, SCG_WAKE_SETTLE, SCG_WAKE_RUN} scg_wake_type;
    scg_wake_type wake_state;
    logic [31:0] wake_cnt;
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            wake_state <= SCG_WAKE_OSC;
            wake_cnt <= 32'h00000000;
        end
        else
        begin
            case (wake_state)
                SCG_WAKE_OSC:
                begin
                    if (osc_tick)
                    begin
                        if (wake_cnt + 32'h1 >= (is_crystal(source) ?
                            32'(SCG_WAKE_CRYSTAL_CYCLES) : 32'(SCG_WAKE_OTHER_CYCLES)))
                        begin
                            wake_state <= SCG_WAKE_SETTLE;
                            wake_cnt <= 32'h00000000;
                        end
                        else
                            wake_cnt <= wake_cnt + 32'h1;
                    end
                end
                SCG_WAKE_SETTLE:
                begin
                    if (wake_cnt + 32'h1 >= 32'(SETTLE_CYCLES))
                    begin
                        wake_state <= SCG_WAKE_RUN;
                        wake_cnt <= 32'h00000000;
                    end
                    else
                        wake_cnt <= wake_cnt + 32'h1;
                end
                SCG_WAKE_RUN:
                begin
                    if (WAKE_I)
                        wake_state <= SCG_WAKE_OSC;
                end
                default: wake_state <= SCG_WAKE_OSC;
            endcase
        end
    end
    assign CPU_HELD_O = (wake_state != SCG_WAKE_RUN);

    // ------------------------------------------------------------
    // CPU clock divider: factor = divider value + 1
    // ------------------------------------------------------------
    logic [7:0] div_cnt;
    logic cpu_tick;
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            div_cnt <= 8'h00;
        else if (osc_tick)
            div_cnt <= (div_cnt >= divider) ? 8'h00 : div_cnt + 8'h01;
    end
    assign cpu_tick = osc_tick && (div_cnt >= divider) && !CPU_HELD_O;

    logic phase;
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            phase <= 1'b0;
        else if (cpu_tick)
            phase <= ~phase;
    end

    // Registered enables; each is one-cycle pulse per CPU or peripheral tick
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            CPU_CLOCK_EN_O <= 1'b0;
            MACHINE_CYCLE_O <= 1'b0;
            PERIPH_CLOCK_EN_O <= 1'b0;
        end
        else
        begin
            CPU_CLOCK_EN_O <= cpu_tick;
            MACHINE_CYCLE_O <= cpu_tick && phase;
            PERIPH_CLOCK_EN_O <= cpu_tick && phase;
        end
    end

    // ------------------------------------------------------------
    // Clock output on the second crystal pin
    // ------------------------------------------------------------
    // crystal unused
    logic clock_output_pin_allowed;
    assign clock_output_pin_allowed = !is_crystal(source) && !RTC_USES_CRYSTAL_I;

    // glitch-free gate
    // Enable only changes while the output sits low, so no short pulse
    logic clock_output_pin_active;
    logic clock_output_pin_level;
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            clock_output_pin_active <= 1'b0;
            clock_output_pin_level <= 1'b0;
        end
        else
        begin
            if (!clock_output_pin_level)
                clock_output_pin_active <= clock_output_pin_en && clock_output_pin_allowed;
            if (clock_output_pin_active)
                clock_output_pin_level <= phase;
            else
                clock_output_pin_level <= 1'b0;
        end
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
        begin
            CRYSTAL_OUTPUT_PIN_O <= 1'b0;
            CRYSTAL_OUTPUT_PIN_OE_O <= 1'b0;
        end
        else if (clock_output_pin_active)
        begin
            CRYSTAL_OUTPUT_PIN_O <= clock_output_pin_level;
            CRYSTAL_OUTPUT_PIN_OE_O <= 1'b1;
        end
        else
        begin
            CRYSTAL_OUTPUT_PIN_O <= PORT_OUT_I;
            CRYSTAL_OUTPUT_PIN_OE_O <= PORT_OE_I && !is_crystal(source);
        end
    end

    // ------------------------------------------------------------
    // Read data; unused bits read zero
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_I)
    begin
        if (SRST_I)
            HRDATA <= 32'h00000000;
        else if (bus_go && !HWRITE)
        begin
            case (HADDR[9:0])
                SCG_TUNING_ADDR: HRDATA <= {25'h0, clock_output_pin_en, tune};
                SCG_DIVIDER_ADDR: HRDATA <= {24'h0, divider};
                SCG_STATUS_ADDR: HRDATA <= {27'h0, clock_output_pin_active, CPU_HELD_O, source};
                default: HRDATA <= 32'h00000000;
            endcase
        end
    end
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
endmodule // scg_top

// ### dv/scg_osc_model.sv
// Behavioural model of the oscillators and the external clock source
`timescale 1ns/1ps
module scg_osc_model
#(
    parameter real XTAL_HALF_NS = 42.0,
    parameter real RC_HALF_NS = 69.0,
    parameter real WDOG_HALF_NS = 1250.0
)
(
    // Control from the bench
    input wire logic stop_i,
    // Oscillator outputs
    output logic xtal_o,
    output logic rc_o,
    output logic wdog_o
);
    // On-chip sources run free and unrelated to the bench clock
    initial rc_o = 1'b0;
    always #(RC_HALF_NS) rc_o = !rc_o;
    initial wdog_o = 1'b0;
    always #(WDOG_HALF_NS) wdog_o = !wdog_o;
    initial xtal_o = 1'b0;
    always #(XTAL_HALF_NS) xtal_o = stop_i ? 1'b0 : !xtal_o;
endmodule // scg_osc_model

// ### dv/scg_top_monitor.sv
// Port-level checker of the clock generation block
`timescale 1ns/1ps
module scg_top_monitor
    import scg_pkg::*;
#(
    parameter int SETTLE_CYCLES = 10,
    parameter int DIV_MAX = 256
)
(
    // Clock, resets and configuration
    input wire logic CLOCK_I,
    input wire logic SRST_I,
    input wire logic POR_I,
    input wire logic [2:0] OSC_SOURCE_CFG_I,
    input wire logic RTC_USES_CRYSTAL_I,
    input wire logic [5:0] TUNE_FACTORY_I,
    input wire logic PORT_OE_I,
    // Pin and clock outputs
    input wire logic CRYSTAL_OUTPUT_PIN_O,
    input wire logic CRYSTAL_OUTPUT_PIN_OE_O,
    input wire logic CPU_CLOCK_EN_O,
    input wire logic MACHINE_CYCLE_O,
    input wire logic PERIPH_CLOCK_EN_O,
    input wire logic CPU_HELD_O,
    input wire logic [5:0] RC_TUNE_O,
    // Bus
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic HREADYOUT,
    input wire logic HRESP
);
    logic [7:0] mc_ticks;
    logic [7:0] pc_ticks;
    logic [7:0] rtc_ticks;
    logic [2:0] busy_hist;
    logic tune_wr;
    logic [5:0] tune_wd;
    logic quiet;
    logic rtc_hold;
    assign quiet = !PORT_OE_I && busy_hist == 3'h0;
    assign rtc_hold = RTC_USES_CRYSTAL_I && !PORT_OE_I && OSC_SOURCE_CFG_I >= 3'h3;
    // CPU ticks since the last machine-cycle and peripheral pulse
    always_ff @(posedge CLOCK_I)
        mc_ticks <= (SRST_I || MACHINE_CYCLE_O) ? 8'h00 : mc_ticks + 8'(CPU_CLOCK_EN_O);
    always_ff @(posedge CLOCK_I)
        pc_ticks <= (SRST_I || PERIPH_CLOCK_EN_O) ? 8'h00 : pc_ticks + 8'(CPU_CLOCK_EN_O);
    // Saturating tick count while the crystal is claimed by the timekeeper
    always_ff @(posedge CLOCK_I)
        rtc_ticks <= (rtc_hold && !SRST_I) ? rtc_ticks + 8'(CPU_CLOCK_EN_O && rtc_ticks < 8'h0F) : 8'h00;
    // Port use or power-on reset lately; pin edges then are not clock gating
    always_ff @(posedge CLOCK_I)
        busy_hist <= {busy_hist[1:0], PORT_OE_I || POR_I};
    // Tuning write data captured at its data phase
    always_ff @(posedge CLOCK_I)
        tune_wr <= HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == 32'(SCG_TUNING_ADDR);
    always_ff @(posedge CLOCK_I)
        if (tune_wr)
            tune_wd <= HWDATA[5:0];
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (SRST_I);
    sequence tune_addr_s;
        HSEL && HREADY && HTRANS[1] && HWRITE && HADDR == 32'(SCG_TUNING_ADDR);
    endsequence
    sequence held_s;
        CPU_HELD_O ##1 CPU_HELD_O;
    endsequence
    a_mc_two_ticks: assert property (mc_ticks <= 8'h01 &&
        (!MACHINE_CYCLE_O || mc_ticks == 8'h01))
        else $error("machine cycle not every second cpu tick");
    a_periph_half_rate: assert property (pc_ticks <= 8'h01 &&
        (!PERIPH_CLOCK_EN_O || pc_ticks == 8'h01))
        else $error("peripheral enable not at half cpu rate");
    a_held_no_tick: assert property (held_s |-> !CPU_CLOCK_EN_O)
        else $error("cpu tick while held");
    a_clock_output_pin_low_on: assert property ($rose(CRYSTAL_OUTPUT_PIN_OE_O) && quiet |-> !CRYSTAL_OUTPUT_PIN_O)
        else $error("clock output enabled in high phase");
    a_clock_output_pin_low_off: assert property ($fell(CRYSTAL_OUTPUT_PIN_OE_O) && quiet |-> !$past(CRYSTAL_OUTPUT_PIN_O))
        else $error("clock output cut in high phase");
    a_clock_output_pin_rtc_off: assert property (rtc_ticks >= 8'h03 |-> !CRYSTAL_OUTPUT_PIN_OE_O)
        else $error("clock output while crystal in use");
    a_tune_write: assert property (tune_addr_s ##1 1'b1 |=> ##[0:1] RC_TUNE_O == tune_wd)
        else $error("tuning write not applied");
    a_tune_por: assert property ($fell(POR_I) |-> ##[0:2] RC_TUNE_O == TUNE_FACTORY_I)
        else $error("factory tuning not loaded");
    a_tune_keep_srst: assert property (@(posedge CLOCK_I) disable iff (POR_I)
        SRST_I && $past(SRST_I) |-> $stable(RC_TUNE_O)) else $error("tuning lost on reset");
    a_bus_okay: assert property (HREADYOUT && !HRESP)
        else $error("bus wait or error response");
endmodule // scg_top_monitor

// ### dv/scg_top_tb_top.sv
// Self-checking bench for the clock generation block
`timescale 1ns/1ps
module scg_top_tb_top;
    import scg_pkg::*;
    localparam int SETTLE = 10;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic por = 1'b1;
    logic [2:0] cfg = 3'h3;
    logic rtc = 1'b0;
    logic [5:0] tune_f = 6'h00;
    logic wake = 1'b0;
    logic p_out = 1'b0;
    logic p_oe = 1'b0;
    logic stop = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic rd_dp = 1'b0;
    logic xtal, rc, wdog, pin, pin_oe, tick, mc, pclk, held, valid, hready, hresp, p;
    logic [5:0] tune, t;
    logic [7:0] divs[4];
    logic [31:0] hrdata;
    logic [63:0] note;
    logic [63:0] exp_q[$];
    int bad_count = 0;
    int total_checks = 0;
    int rises = 0;
    int seed, n, c;
    always #4 clk = !clk;
    // Edges of the selected source, used to measure the divider
    always @(posedge (cfg == 3'h7 ? xtal : rc))
        rises++;
    scg_osc_model scg_osc_model_i (.stop_i(stop), .xtal_o(xtal), .rc_o(rc), .wdog_o(wdog));
    scg_top #(.SETTLE_CYCLES(SETTLE), .DIV_MAX(256)) scg_top_i (
        .CLOCK_I(clk), .SRST_I(srst), .POR_I(por), .OSC_SOURCE_CFG_I(cfg),
        .RTC_USES_CRYSTAL_I(rtc), .TUNE_FACTORY_I(tune_f), .CRYSTAL_INPUT_PIN_I(xtal),
        .INTERNAL_RC_CLOCK_I(rc), .WATCHDOG_OSC_I(wdog), .WAKE_I(wake), .PORT_OUT_I(p_out),
        .PORT_OE_I(p_oe), .CRYSTAL_OUTPUT_PIN_O(pin), .CRYSTAL_OUTPUT_PIN_OE_O(pin_oe),
        .CPU_CLOCK_EN_O(tick), .MACHINE_CYCLE_O(mc), .PERIPH_CLOCK_EN_O(pclk),
        .CPU_HELD_O(held), .RC_TUNE_O(tune), .XTAL_RANGE_VALID_O(valid), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // One single-word transfer; ready is awaited in both phases
    // Select stays high between transfers; an idle htrans ends the request
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp <= !wr;
        do @(posedge clk); while (hready !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] m, input logic [31:0] e);
        exp_q.push_back({m, e});
        bus(1'b0, a, hwdata);
    endtask
    // Read data is compared with the oldest note at each read data phase
    always @(posedge clk)
        if (rd_dp && hready === 1'b1)
        begin
            note = exp_q.pop_front();
            check(hrdata & note[63:32], note[31:0]);
        end
    task automatic ticks(input int k);
        repeat (k) do @(posedge clk); while (tick !== 1'b1);
    endtask
    task automatic meas(input logic [7:0] d);
        int r0;
        bus(1'b1, SCG_DIVIDER_ADDR, {24'h0, d});
        ticks(2);
        r0 = rises;
        ticks(1);
        check(32'(rises - r0), 32'(d) + 32'h1);
    endtask
    task automatic hold_chk(input int lo);
        int hc;
        hc = 0;
        while (held !== 1'b0)
            @(posedge clk) hc++;
        check(32'(hc >= lo - 4 && hc <= lo + SETTLE + 12), 32'h1);
    endtask
    initial
    begin
        seed = $urandom(95778);
        tune_f = 6'($urandom);
        divs = '{8'h00, 8'h03, 8'($urandom_range(1, 254)), 8'hFF};
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        por <= 1'b0;
        hold_chk(224 * 138 / 8);
        rd(SCG_TUNING_ADDR, 32'hFFFFFFFF, {26'h0, tune_f});
        rd(SCG_DIVIDER_ADDR, 32'hFFFFFFFF, 32'(SCG_DIVIDER_RESET));
        rd(SCG_STATUS_ADDR, 32'h7, 32'h3);
        bus(1'b1, SCG_PORT_ADDR, 32'hFFFFFFFF);
        rd(SCG_PORT_ADDR, 32'hFFFFFFFF, 32'h0);
        foreach (divs[i]) meas(divs[i]);
        rd(SCG_DIVIDER_ADDR, 32'hFFFFFFFF, 32'hFF);
        meas(8'h00);
        t = 6'($urandom);
        bus(1'b1, SCG_TUNING_ADDR, {26'h0, t});
        rd(SCG_TUNING_ADDR, 32'hFFFFFFFF, {26'h0, t});
        check(32'(tune), 32'(t));
        // Plain reset mid-run keeps the tuning; a wake request restarts the hold
        srst <= 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        hold_chk(224 * 138 / 8);
        check(32'(tune), 32'(t));
        wake <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        repeat (3) @(posedge clk);
        check(32'(held), 32'h1);
        hold_chk(224 * 138 / 8 - 3);
        bus(1'b1, SCG_DIVIDER_ADDR, 32'h0);
        // Clock output: one pin change per cpu tick
        bus(1'b1, SCG_TUNING_ADDR, {26'h1, t});
        ticks(4);
        check(32'(pin_oe), 32'h1);
        n = 0;
        c = 0;
        p = pin;
        for (int i = 0; i < 400; i++)
        begin
            @(posedge clk);
            n += int'(tick);
            c += int'(pin !== p);
            p = pin;
        end
        check(32'(c >= n - 1 && c <= n + 1), 32'h1);
        rtc <= 1'b1;
        ticks(4);
        check(32'(pin_oe), 32'h0);
        rtc <= 1'b0;
        ticks(4);
        check(32'(pin_oe), 32'h1);
        bus(1'b1, SCG_TUNING_ADDR, {26'h0, t});
        ticks(4);
        check(32'(pin_oe), 32'h0);
        p = 1'($urandom);
        p_out <= p;
        p_oe <= 1'b1;
        repeat (4) @(posedge clk);
        check(32'({pin_oe, pin}), 32'({1'b1, p}));
        p_oe <= 1'b0;
        // Power-on reset reloads the factory tuning and clears the output enable
        bus(1'b1, SCG_TUNING_ADDR, {26'h1, ~t});
        por <= 1'b1;
        repeat (2) @(posedge clk);
        por <= 1'b0;
        repeat (3) @(posedge clk);
        rd(SCG_TUNING_ADDR, 32'hFFFFFFFF, {26'h0, tune_f});
        // External clock source, including a stopped clock
        cfg <= 3'h7;
        srst <= 1'b1;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        hold_chk(224 * 84 / 8);
        meas(8'h01);
        stop <= 1'b1;
        repeat (50) @(posedge clk);
        n = 0;
        repeat (200) @(posedge clk) n += int'(tick);
        check(32'(n), 32'h0);
        stop <= 1'b0;
        ticks(2);
        for (int i = 0; i < 8; i++)
        begin
            cfg <= 3'(i);
            repeat (4) @(posedge clk);
            check(32'(valid), 32'(i < 5 || i == 7));
        end
        print_verdict();
    end
    // Cuts a hang short
    initial
    begin
        repeat (90000) @(posedge clk);
        bad_count++;
        print_verdict();
    end
endmodule // scg_top_tb_top
bind scg_top scg_top_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES), .DIV_MAX(DIV_MAX)) scg_top_monitor_i (
    .CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .POR_I(POR_I), .OSC_SOURCE_CFG_I(OSC_SOURCE_CFG_I),
    .RTC_USES_CRYSTAL_I(RTC_USES_CRYSTAL_I), .TUNE_FACTORY_I(TUNE_FACTORY_I),
    .PORT_OE_I(PORT_OE_I), .CRYSTAL_OUTPUT_PIN_O(CRYSTAL_OUTPUT_PIN_O),
    .CRYSTAL_OUTPUT_PIN_OE_O(CRYSTAL_OUTPUT_PIN_OE_O), .CPU_CLOCK_EN_O(CPU_CLOCK_EN_O),
    .MACHINE_CYCLE_O(MACHINE_CYCLE_O), .PERIPH_CLOCK_EN_O(PERIPH_CLOCK_EN_O),
    .CPU_HELD_O(CPU_HELD_O), .RC_TUNE_O(RC_TUNE_O), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP));
